// ### src/cmp_option_routing.sv
// Comparator option routing and port A pin multiplexing with an APB register file
`timescale 1ns/10ps

// What this block does
// - Debug enable clear disables debug and ICE
// - Capture select feeds comparator to channel 0
// - Capture select cuts timer channel 0 pin
// - IRQ pin has switchable pullup
// - Reset pin function forces integrated pullup
// - Debug pin function forces pullup on bit 4
// - IIC pins relocatable, default bits 2,3
// - Keyboard edge select turns pullup to pulldown
// - Input pins offer software pullup
// - Output pins offer slew and drive
// - Comparator pin driven only when enabled
// - Bandgap select picks positive comparator input
module cmp_option_routing
  import cmp_route_pkg::*;
(
  input  wire logic        sys_clk,        // Bus clock, 100 MHz
  input  wire logic        rst_n,          // Async reset, active low
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB enable
  input  wire logic        pwrite,         // APB write
  input  wire logic [7:0]  paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic [31:0]      prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error, unmapped address
  input  wire logic        cmp_raw,        // Analog comparator result
  input  wire logic [7:0]  port_in,        // Pad input levels
  input  wire logic        tmr_ch0_out,    // Timer channel 0 output value
  input  wire logic        tmr_ch0_oe,     // Timer channel 0 drives pin
  input  wire logic        iic_enable,     // IIC module owns its pins
  input  wire logic        iic_sda_oe,     // IIC data pulls low
  input  wire logic        iic_scl_oe,     // IIC clock pulls low
  input  wire logic        dbg_out,        // Debug pin output value
  input  wire logic        dbg_oe,         // Debug pin output enable
  output logic             bandgap_select, // Positive input is reference
  output logic             bandgap_buffer, // Bandgap buffer enable
  output logic             debug_mode_en,  // Background debug allowed
  output logic             ice_en,         // In-circuit emulation allowed
  output logic             tmr_capture0_in,// Timer capture channel 0 input
  output logic             iic_sda_in,     // IIC data from selected pin
  output logic             iic_scl_in,     // IIC clock from selected pin
  output logic             irq_in,         // IRQ level from bit 5
  output logic             reset_pin_in,   // Reset level from bit 5
  output logic [7:0]       port_out,       // Pad output values
  output logic [7:0]       port_oe,        // Pad output enables
  output logic [7:0]       port_pullup,    // Pad pullups
  output logic [7:0]       port_pulldown,  // Pad pulldowns
  output logic [7:0]       port_slew,      // Pad slew limiting
  output logic [7:0]       port_drive      // Pad high drive
);

  // ==========================================================================
  // Registers
  logic [3:0] opt_first;
  logic [1:0] opt_second;
  logic       power_bgbuf;
  logic [7:0] cmp_ctrl;
  logic [7:0] port_dir;
  logic [7:0] port_pull;
  logic [7:0] port_slew_r;
  logic [7:0] port_drive_r;
  logic [7:0] kbi_en;
  logic [7:0] kbi_edge;
  logic [7:0] port_data;
  logic       cmp_flag;

  logic       cmp_out;
  logic       cmp_event;

  // ==========================================================================
  // APB decode
  wire setup_rd   = psel & ~penable;
  wire wr_commit  = psel & penable & pready & pwrite;
  wire hit_opt1   = paddr == OFS_OPT_FIRST;
  wire hit_opt2   = paddr == OFS_OPT_SECOND;
  wire hit_power  = paddr == OFS_POWER;
  wire hit_cmp    = paddr == OFS_CMP_CTRL;
  wire hit_dir    = paddr == OFS_PORT_DIR;
  wire hit_pull   = paddr == OFS_PORT_PULL;
  wire hit_slew   = paddr == OFS_PORT_SLEW;
  wire hit_drive  = paddr == OFS_PORT_DRIVE;
  wire hit_kbien  = paddr == OFS_KBI_EN;
  wire hit_kbiedg = paddr == OFS_KBI_EDGE;
  wire hit_out    = paddr == OFS_PORT_OUT;
  wire hit_in     = paddr == OFS_PORT_IN;
  wire mapped     = hit_opt1 | hit_opt2 | hit_power | hit_cmp | hit_dir | hit_pull
                  | hit_slew | hit_drive | hit_kbien | hit_kbiedg | hit_out | hit_in;
  wire flag_clr   = wr_commit & hit_cmp & pwdata[BIT_CMP_FLAG];

  wire debug_pin_en = opt_first[BIT_DEBUG_PIN_EN];
  wire reset_pin_en = opt_first[BIT_RESET_PIN_EN];
  wire irq_pin_en   = opt_first[BIT_IRQ_PIN_EN];
  wire irq_pull_dis = opt_first[BIT_IRQ_PULL_DIS];
  wire capture_sel  = opt_second[BIT_CAPTURE_SEL];
  wire iic_loc_sel  = opt_second[BIT_IIC_LOC_SEL];
  wire cmp_enable   = cmp_ctrl[BIT_CMP_ENABLE];
  wire cmp_pin_en   = cmp_ctrl[BIT_CMP_PIN_EN];

  wire [7:0] cmp_ctrl_rd = {cmp_ctrl[7:6], cmp_flag, cmp_ctrl[4], cmp_out, cmp_ctrl[2:0]};

  wire [31:0] rd_mux =
      hit_opt1   ? {28'h0000000, opt_first}    :
      hit_opt2   ? {30'h0, opt_second}         :
      hit_power  ? {31'h0, power_bgbuf}        :
      hit_cmp    ? {24'h000000, cmp_ctrl_rd}   :
      hit_dir    ? {24'h000000, port_dir}      :
      hit_pull   ? {24'h000000, port_pull}     :
      hit_slew   ? {24'h000000, port_slew_r}   :
      hit_drive  ? {24'h000000, port_drive_r}  :
      hit_kbien  ? {24'h000000, kbi_en}        :
      hit_kbiedg ? {24'h000000, kbi_edge}      :
      hit_out    ? {24'h000000, port_data}     :
      hit_in     ? {24'h000000, port_in}       : 32'h00000000;

  // One wait-free access phase: ready is raised in the cycle after setup
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup_rd;
      pslverr <= setup_rd & ~mapped;
      // Loaded at setup so it stands through the whole access phase
      if (setup_rd && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // ==========================================================================
  // Register file
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      opt_first    <= RST_OPT_FIRST;
      opt_second   <= RST_OPT_SECOND;
      power_bgbuf  <= 1'b0;
      cmp_ctrl     <= RST_CMP_CTRL;
      port_dir     <= RST_PORT;
      port_pull    <= RST_PORT;
      port_slew_r  <= RST_PORT;
      port_drive_r <= RST_PORT;
      kbi_en       <= RST_PORT;
      kbi_edge     <= RST_PORT;
      port_data    <= RST_PORT;
    end else if (wr_commit) begin
      if (hit_opt1)   opt_first    <= pwdata[3:0];
      if (hit_opt2)   opt_second   <= pwdata[1:0];
      if (hit_power)  power_bgbuf  <= pwdata[BIT_BANDGAP_BUF];
      if (hit_cmp)    cmp_ctrl     <= {pwdata[7:6], 1'b0, pwdata[4], 1'b0, pwdata[2:0]};
      if (hit_dir)    port_dir     <= pwdata[7:0];
      if (hit_pull)   port_pull    <= pwdata[7:0];
      if (hit_slew)   port_slew_r  <= pwdata[7:0];
      if (hit_drive)  port_drive_r <= pwdata[7:0];
      if (hit_kbien)  kbi_en       <= pwdata[7:0];
      if (hit_kbiedg) kbi_edge     <= pwdata[7:0];
      if (hit_out)    port_data    <= pwdata[7:0];
    end
  end

  // Write-one-to-clear flag; a new event in the clearing cycle keeps it set
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_flag <= 1'b0;
    end else begin
      cmp_flag <= cmp_event | (cmp_flag & ~flag_clr);
    end
  end

  cmp_event_detect u_event (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .enable  (cmp_enable),
    .cmp_raw (cmp_raw),
    .mode    (cmp_mode_t'(cmp_ctrl[1:0])),
    .cmp_out (cmp_out),
    .event_p (cmp_event)
  );

  // ==========================================================================
  // Alternate function selection per pin
  logic [7:0] alt_sel;
  logic [7:0] alt_out;
  logic [7:0] alt_oe;
  logic [7:0] force_pu;
  logic [7:0] isolate;

  wire iic_at_low  = iic_enable & ~iic_loc_sel;
  wire iic_at_high = iic_enable & iic_loc_sel;
  wire cmp_pin_act = cmp_pin_en & ~debug_pin_en;
  wire bit5_func   = reset_pin_en | irq_pin_en;

  assign alt_sel = {iic_at_high, iic_at_high, bit5_func, debug_pin_en | cmp_pin_act,
                    iic_at_low, iic_at_low, 1'b0, tmr_ch0_oe};
  // Open-drain IIC lines only ever pull low
  assign alt_out = {1'b0, 1'b0, 1'b0, debug_pin_en ? dbg_out : cmp_out,
                    1'b0, 1'b0, 1'b0, tmr_ch0_out};
  assign alt_oe  = {iic_scl_oe, iic_sda_oe, 1'b0, debug_pin_en ? dbg_oe : 1'b1,
                    iic_scl_oe, iic_sda_oe, 1'b0, 1'b1};
  // Debug pin pullup on bit 4
  assign force_pu = {2'b00, reset_pin_en | (irq_pin_en & ~irq_pull_dis),
                     debug_pin_en, 4'h0};
  assign isolate  = {7'h00, capture_sel};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pad
      pin_pad_cfg u_pad (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .dir          (port_dir[gi]),
        .sw_out       (port_data[gi]),
        .sw_pullup    (port_pull[gi]),
        .slew_en      (port_slew_r[gi]),
        .drive_hi     (port_drive_r[gi]),
        .kbi_en       (kbi_en[gi]),
        .kbi_edge     (kbi_edge[gi]),
        .alt_sel      (alt_sel[gi]),
        .alt_out      (alt_out[gi]),
        .alt_oe       (alt_oe[gi]),
        .force_pullup (force_pu[gi]),
        .isolate      (isolate[gi]),
        .pad_out      (port_out[gi]),
        .pad_oe       (port_oe[gi]),
        .pad_pullup   (port_pullup[gi]),
        .pad_pulldown (port_pulldown[gi]),
        .pad_slew     (port_slew[gi]),
        .pad_drive    (port_drive[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Function inputs and option outputs
  // IIC location select
  wire next_sda = iic_loc_sel ? port_in[PIN_IIC_SDA1] : port_in[PIN_IIC_SDA0];
  wire next_scl = iic_loc_sel ? port_in[PIN_IIC_SCL1] : port_in[PIN_IIC_SCL0];
  wire next_cap = capture_sel ? cmp_out : port_in[PIN_TIMER_CH0];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bandgap_select  <= 1'b0;
      bandgap_buffer  <= 1'b0;
      debug_mode_en   <= 1'b1;
      ice_en          <= 1'b1;
      tmr_capture0_in <= 1'b0;
      iic_sda_in      <= 1'b1;
      iic_scl_in      <= 1'b1;
      irq_in          <= 1'b1;
      reset_pin_in    <= 1'b1;
    end else begin
      bandgap_select  <= cmp_ctrl[BIT_BANDGAP_SEL];
      bandgap_buffer  <= power_bgbuf;
      // Debug and ICE follow pin enable
      debug_mode_en   <= debug_pin_en;
      ice_en          <= debug_pin_en;
      tmr_capture0_in <= next_cap;
      iic_sda_in      <= next_sda;
      iic_scl_in      <= next_scl;
      // Unused pin functions see their inactive high level
      irq_in          <= irq_pin_en ? port_in[PIN_IRQ_RESET] : 1'b1;
      reset_pin_in    <= reset_pin_en ? port_in[PIN_IRQ_RESET] : 1'b1;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_debug_off_follow: assert property (!debug_pin_en |=> !debug_mode_en && !ice_en)
    else $error("debug or ICE still enabled with debug pin disabled");
  a_capture_from_cmp: assert property (capture_sel |=> tmr_capture0_in == $past(cmp_out))
    else $error("capture channel 0 not fed by comparator");
  a_ch0_isolated: assert property (capture_sel |=> !port_oe[0] && !port_pullup[0])
    else $error("timer channel 0 pin not isolated");
  a_irq_pullup_sw: assert property (irq_pin_en && !reset_pin_en |=>
                                    port_pullup[5] == !$past(irq_pull_dis))
    else $error("irq pullup does not follow its disable");
  a_reset_pullup: assert property (reset_pin_en |=> port_pullup[5])
    else $error("reset pin lacks pullup");
  a_debug_pullup: assert property (debug_pin_en |=> port_pullup[4] && !port_pulldown[4])
    else $error("debug pin lacks pullup");
  a_iic_location: assert property (!iic_loc_sel |=> iic_sda_in == $past(port_in[2])
                                   && iic_scl_in == $past(port_in[3]))
    else $error("iic pins not at default location");
  a_kbi_pulldown: assert property (kbi_en[1] && port_pull[1] && kbi_edge[1]
                                   && !port_dir[1] |=> port_pulldown[1] && !port_pullup[1])
    else $error("keyboard edge select did not give pulldown");
  a_input_pullup: assert property (!port_dir[1] && port_pull[1] && !kbi_en[1]
                                   |=> port_pullup[1])
    else $error("input pullup missing");
  a_output_slew: assert property (port_dir[1] |=> port_slew[1] == $past(port_slew_r[1])
                                  && port_drive[1] == $past(port_drive_r[1]))
    else $error("output slew or drive not applied");
  a_cmp_pin_gate: assert property (!debug_pin_en && !cmp_pin_en |=> !port_oe[4])
    else $error("comparator pin driven while disabled");
  // Debug owns bit 4 whenever both enables are set
  a_cmp_pin_drive: assert property (cmp_pin_act |=> port_oe[4]
                                    && port_out[4] == $past(cmp_out))
    else $error("comparator pin not driven");
  a_bandgap_sel: assert property (##1 bandgap_select == $past(cmp_ctrl[BIT_BANDGAP_SEL]))
    else $error("bandgap select not applied");
  a_flag_sticky: assert property (cmp_event |=> cmp_flag)
    else $error("compare event lost");
  a_flag_clear: assert property (flag_clr && !cmp_event |=> !cmp_flag)
    else $error("compare flag not cleared");
  a_cmp_out_gate: assert property (!cmp_enable |=> !cmp_out)
    else $error("comparator output seen while disabled");
  a_debug_on_follow: assert property (debug_pin_en |=> debug_mode_en && ice_en)
    else $error("debug or ICE off with debug pin enabled");
  a_bit5_input: assert property (bit5_func |=> !port_oe[5])
    else $error("irq or reset pin driven");
  a_iic_relocated: assert property (iic_loc_sel |=> iic_sda_in == $past(port_in[6])
                                    && iic_scl_in == $past(port_in[7]))
    else $error("iic pins not at relocated position");

  // Bus handshake: exactly one ready pulse for every setup cycle
  a_ready_pulse: assert property (setup_rd |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_unmapped_err: assert property (setup_rd && !mapped |=> pslverr)
    else $error("unmapped access without error");

  // ==========================================================================
  // Coverage
  c_cmp_pin_out:   cover property (cmp_pin_act ##1 port_oe[4]);
  c_capture_route: cover property (capture_sel && cmp_out);
  c_flag_clear:    cover property (cmp_flag && flag_clr ##1 !cmp_flag);
  c_iic_relocate:  cover property (iic_at_high ##1 port_oe[6]);
  c_kbi_pulldown:  cover property (port_pulldown[1]);

endmodule : cmp_option_routing

// ### src/cmp_route_pkg.sv
// Shared constants and types for the comparator option and pin routing block
package cmp_route_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_OPT_FIRST  = 8'h00;
  localparam logic [7:0] OFS_OPT_SECOND = 8'h04;
  localparam logic [7:0] OFS_POWER      = 8'h08;
  localparam logic [7:0] OFS_CMP_CTRL   = 8'h0C;
  localparam logic [7:0] OFS_PORT_DIR   = 8'h10;
  localparam logic [7:0] OFS_PORT_PULL  = 8'h14;
  localparam logic [7:0] OFS_PORT_SLEW  = 8'h18;
  localparam logic [7:0] OFS_PORT_DRIVE = 8'h1C;
  localparam logic [7:0] OFS_KBI_EN     = 8'h20;
  localparam logic [7:0] OFS_KBI_EDGE   = 8'h24;
  localparam logic [7:0] OFS_PORT_OUT   = 8'h28;
  localparam logic [7:0] OFS_PORT_IN    = 8'h2C;

  // ==========================================================================
  // Field positions
  localparam int BIT_DEBUG_PIN_EN  = 0;
  localparam int BIT_RESET_PIN_EN  = 1;
  localparam int BIT_IRQ_PIN_EN    = 2;
  localparam int BIT_IRQ_PULL_DIS  = 3;
  localparam int BIT_CAPTURE_SEL   = 0;
  localparam int BIT_IIC_LOC_SEL   = 1;
  localparam int BIT_BANDGAP_BUF   = 0;
  localparam int BIT_CMP_ENABLE    = 7;
  localparam int BIT_BANDGAP_SEL   = 6;
  localparam int BIT_CMP_FLAG      = 5;
  localparam int BIT_CMP_IE        = 4;
  localparam int BIT_CMP_OUT       = 3;
  localparam int BIT_CMP_PIN_EN    = 2;

  // ==========================================================================
  // Pin assignment within port A
  localparam int PIN_TIMER_CH0 = 0;
  localparam int PIN_IIC_SDA0  = 2;
  localparam int PIN_IIC_SCL0  = 3;
  localparam int PIN_DEBUG     = 4;
  localparam int PIN_IRQ_RESET = 5;
  localparam int PIN_IIC_SDA1  = 6;
  localparam int PIN_IIC_SCL1  = 7;

  // ==========================================================================
  // Reset values
  localparam logic [3:0] RST_OPT_FIRST  = 4'h1;
  localparam logic [1:0] RST_OPT_SECOND = 2'h0;
  localparam logic [7:0] RST_CMP_CTRL   = 8'h00;
  localparam logic [7:0] RST_PORT       = 8'h00;

  typedef enum logic [1:0] {
    MODE_FALL0  = 2'b00,
    MODE_RISE   = 2'b01,
    MODE_FALL2  = 2'b10,
    MODE_TOGGLE = 2'b11
  } cmp_mode_t;

endpackage : cmp_route_pkg

// ### src/cmp_event_detect.sv
// Comparator output sampling and compare event detection
`timescale 1ns/10ps
module cmp_event_detect
  import cmp_route_pkg::*;
(
  input  wire logic      sys_clk,  // Bus clock
  input  wire logic      rst_n,    // Async reset, active low
  input  wire logic      enable,   // Comparator enabled
  input  wire logic      cmp_raw,  // Comparator result
  input  wire cmp_mode_t mode,     // Event type
  output logic           cmp_out,  // Gated comparator output
  output logic           event_p   // One-cycle compare event
);

  logic next_out;
  logic rise;
  logic fall;

  // Output reads zero while disabled, so enabling with the result high gives a rising edge
  assign next_out = enable & cmp_raw;
  assign rise     = next_out & ~cmp_out;
  assign fall     = ~next_out & cmp_out;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_out <= 1'b0;
      event_p <= 1'b0;
    end else begin
      cmp_out <= next_out;
      case (mode)
        MODE_RISE:   event_p <= enable & rise;
        MODE_TOGGLE: event_p <= enable & (rise | fall);
        default:     event_p <= enable & fall;
      endcase
    end
  end

endmodule : cmp_event_detect

// ### src/pin_pad_cfg.sv
// Per-pin pad control: direction, alternate function, pulls, slew, drive
`timescale 1ns/10ps
module pin_pad_cfg (
  input  wire logic sys_clk,      // Bus clock
  input  wire logic rst_n,        // Async reset, active low
  input  wire logic dir,          // 1 = software output
  input  wire logic sw_out,       // Software output value
  input  wire logic sw_pullup,    // Software pull enable
  input  wire logic slew_en,      // Slew limiting
  input  wire logic drive_hi,     // High drive strength
  input  wire logic kbi_en,       // Keyboard interrupt on this pin
  input  wire logic kbi_edge,     // Keyboard edge select
  input  wire logic alt_sel,      // Alternate function owns the pin
  input  wire logic alt_out,      // Alternate output value
  input  wire logic alt_oe,       // Alternate output enable
  input  wire logic force_pullup, // Integrated pullup request
  input  wire logic isolate,      // Pin cut off from the outside
  output logic      pad_out,      // Pad output value
  output logic      pad_oe,       // Pad output enable
  output logic      pad_pullup,   // Pullup on
  output logic      pad_pulldown, // Pulldown on
  output logic      pad_slew,     // Slew limiting on
  output logic      pad_drive     // High drive on
);

  logic next_oe;
  logic next_pd;
  logic next_pu;

  assign next_oe = ~isolate & (alt_sel ? alt_oe : dir);
  assign next_pd = ~isolate & ~force_pullup & kbi_en & sw_pullup & kbi_edge & ~next_oe;
  assign next_pu = ~isolate & ~next_pd
                 & (force_pullup | (~alt_sel & ~dir & sw_pullup) | (kbi_en & sw_pullup));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out      <= 1'b0;
      pad_oe       <= 1'b0;
      pad_pullup   <= 1'b0;
      pad_pulldown <= 1'b0;
      pad_slew     <= 1'b0;
      pad_drive    <= 1'b0;
    end else begin
      pad_out      <= alt_sel ? alt_out : sw_out;
      pad_oe       <= next_oe;
      pad_pullup   <= next_pu;
      pad_pulldown <= next_pd;
      pad_slew     <= next_oe & slew_en;
      pad_drive    <= next_oe & drive_hi;
    end
  end

endmodule : pin_pad_cfg

// ### dv/board_pins.sv
// Board-side model of the port A pins
`timescale 1ns/10ps
module board_pins (
  input  wire logic       sys_clk, // Bus clock
  input  wire logic [7:0] pad_out, // Pad output values
  input  wire logic [7:0] pad_oe,  // Pad output enables
  input  wire logic [7:0] pad_pu,  // Pad pullups
  input  wire logic [7:0] pad_pd,  // Pad pulldowns
  input  wire logic [7:0] ext_val, // Board drive value
  input  wire logic [7:0] ext_oe,  // Board drives the pin
  output logic      [7:0] port_in  // Resolved pin levels
);
  // =========================================================================
  // Pin resolution
  logic [7:0] drift = 8'h55;
  // Undriven pins without a pull wander, so a stale level never passes
  always_ff @(posedge sys_clk) drift <= ~drift;
  assign port_in = (pad_oe & pad_out) | (~pad_oe & ext_oe & ext_val)
                 | (~pad_oe & ~ext_oe & (pad_pu | (~pad_pd & drift)));
endmodule : board_pins

// ### dv/tb_comparator_option_pin_routing.sv
// Self-checking bench for the comparator option routing block
`timescale 1ns/10ps
module tb_comparator_option_pin_routing;
  import cmp_route_pkg::*;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, cmp_raw, iic_enable;
  logic tmr_ch0_out, tmr_ch0_oe, iic_sda_oe, iic_scl_oe, dbg_out, dbg_oe;
  logic bandgap_select, bandgap_buffer, debug_mode_en, ice_en, tmr_capture0_in;
  logic iic_sda_in, iic_scl_in, irq_in, reset_pin_in, re;
  logic [7:0]  paddr, port_in, port_out, port_oe, port_pullup, port_pulldown;
  logic [7:0]  port_slew, port_drive, ext_val, ext_oe;
  logic [31:0] pwdata, prdata, rq;
  int          bad_count, comparisons, cycles;
  cmp_option_routing u_cmp_option_routing (.sys_clk(sys_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw),
    .port_in(port_in), .tmr_ch0_out(tmr_ch0_out), .tmr_ch0_oe(tmr_ch0_oe),
    .iic_enable(iic_enable), .iic_sda_oe(iic_sda_oe), .iic_scl_oe(iic_scl_oe),
    .dbg_out(dbg_out), .dbg_oe(dbg_oe), .bandgap_select(bandgap_select),
    .bandgap_buffer(bandgap_buffer), .debug_mode_en(debug_mode_en), .ice_en(ice_en),
    .tmr_capture0_in(tmr_capture0_in), .iic_sda_in(iic_sda_in), .iic_scl_in(iic_scl_in),
    .irq_in(irq_in), .reset_pin_in(reset_pin_in), .port_out(port_out),
    .port_oe(port_oe), .port_pullup(port_pullup), .port_pulldown(port_pulldown),
    .port_slew(port_slew), .port_drive(port_drive));
  board_pins u_board_pins (.sys_clk(sys_clk), .pad_out(port_out), .pad_oe(port_oe),
    .pad_pu(port_pullup), .pad_pd(port_pulldown), .ext_val(ext_val), .ext_oe(ext_oe),
    .port_in(port_in));
  // =========================================================================
  // Clock, timeout and reporting
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      print_verdict();
    end
  end
  task print_verdict();
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask : chk
  // =========================================================================
  // APB master: request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Options and pads settle one edge after the write, pin levels routed back through the pads one more
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
    repeat (3) @(posedge sys_clk);
  endtask : wr
  // =========================================================================
  // Scenarios
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, cmp_raw, iic_enable} = '0;
    {tmr_ch0_out, tmr_ch0_oe, iic_sda_oe, iic_scl_oe, dbg_out, dbg_oe} = '0;
    {bad_count, comparisons, cycles} = '0;
    ext_val = 8'h44;
    ext_oe  = 8'hDE;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    iic_enable <= 1'b1;
    wr(8'h30, 0);
    chk("unmapped err", 1, re);
    apb(0, OFS_OPT_FIRST, 0);
    chk("opt first", 32'h1, rq);
    chk("debug en", 1, debug_mode_en);
    chk("pullup4", 1, port_pullup[PIN_DEBUG]);
    chk("sda pin2", 1, iic_sda_in);
    chk("scl pin3", 0, iic_scl_in);
    ext_val <= 8'h84;
    wr(OFS_OPT_SECOND, 32'h2);
    chk("sda pin6", 0, iic_sda_in);
    chk("scl pin7", 1, iic_scl_in);
    // Debug pin released before the comparator pin is used
    wr(OFS_OPT_FIRST, 0);
    chk("debug off", 0, debug_mode_en);
    chk("ice off", 0, ice_en);
    chk("pullup4 off", 0, port_pullup[PIN_DEBUG]);
    // Buffer enabled before the internal reference is chosen
    wr(OFS_POWER, 1);
    chk("bg buffer", 1, bandgap_buffer);
    cmp_raw <= 1;
    wr(OFS_CMP_CTRL, 32'hC4);
    chk("bg select", 1, bandgap_select);
    chk("cmp pin oe", 1, port_oe[PIN_DEBUG]);
    chk("cmp pin hi", 1, port_out[PIN_DEBUG]);
    wr(OFS_CMP_CTRL, 32'h84);
    chk("bg ext", 0, bandgap_select);
    chk("cmp pin oe2", 0, port_oe[PIN_DEBUG] & ~port_out[PIN_DEBUG]);
    wr(OFS_CMP_CTRL, 32'h80);
    chk("cmp pin off", 0, port_oe[PIN_DEBUG]);
    tmr_ch0_oe <= 1;
    tmr_ch0_out <= 1;
    wr(OFS_OPT_SECOND, 0);
    chk("tmr pin oe", 1, port_oe[PIN_TIMER_CH0]);
    wr(OFS_OPT_SECOND, 1);
    chk("capture hi", 1, tmr_capture0_in);
    chk("tmr pin cut", 0, port_oe[PIN_TIMER_CH0]);
    cmp_raw <= 0;
    wr(OFS_PORT_IN, 0);
    chk("capture lo", 0, tmr_capture0_in);
    apb(0, OFS_CMP_CTRL, 0);
    chk("flag falling", 32'hA0, rq);
    wr(OFS_CMP_CTRL, 32'hA1);
    cmp_raw <= 1'b1;
    wr(OFS_PORT_IN, 0);
    apb(0, OFS_CMP_CTRL, 0);
    chk("flag rising", 32'hA9, rq);
    wr(OFS_OPT_FIRST, 32'h2);
    chk("reset pullup", 1, port_pullup[PIN_IRQ_RESET]);
    chk("reset level", 1, reset_pin_in);
    // Board pulls bit 5 low against the pullup to prove the level is routed
    ext_oe <= 8'hFE;
    wr(OFS_OPT_FIRST, 32'h4);
    chk("irq pullup", 1, port_pullup[PIN_IRQ_RESET]);
    chk("irq level", 0, irq_in);
    chk("reset idle", 1, reset_pin_in);
    wr(OFS_OPT_FIRST, 32'hC);
    chk("irq pull off", 0, port_pullup[PIN_IRQ_RESET]);
    wr(OFS_PORT_PULL, 32'h02);
    chk("in pullup", 1, port_pullup[1]);
    wr(OFS_KBI_EN, 32'h02);
    wr(OFS_KBI_EDGE, 32'h02);
    chk("kbi pulldown", 2'b10, {port_pulldown[1], port_pullup[1]});
    iic_enable <= 0;
    wr(OFS_PORT_DIR, 32'h42);
    wr(OFS_PORT_SLEW, 32'h42);
    wr(OFS_PORT_DRIVE, 32'h42);
    wr(OFS_PORT_OUT, 32'h40);
    chk("out pin", 2'b11, {port_oe[6], port_out[6]});
    chk("slew drive", 2'b11, {port_slew[6], port_drive[6]});
    chk("slew drive1", 2'b11, {port_slew[1], port_drive[1]});
    print_verdict();
  end
endmodule : tb_comparator_option_pin_routing
